// >>> src/i2c_slave_receiver_regs.svh
/*
 Register offsets, field positions, reset values and status codes of the
 two-wire slave receiver. Assumes inclusion by bare name from src/.
*/
`ifndef I2C_SLAVE_RECEIVER_REGS_SVH
`define I2C_SLAVE_RECEIVER_REGS_SVH

`define OWN_ADDR_OFFSET 8'h00
`define CONTROL_OFFSET 8'h04
`define STATUS_OFFSET 8'h08
`define DATA_OFFSET 8'h0C

`define CTRL_INT_BIT 7
`define CTRL_ACK_BIT 6
`define CTRL_STA_BIT 5
`define CTRL_STO_BIT 4
`define CTRL_EN_BIT 2
`define GC_ENABLE_BIT 0

`define OWN_ADDR_RESET 8'h00
`define GENERAL_CALL_ADDR 8'h00
`define PRESCALER_MASK 8'hF8
`define BITS_PER_BYTE 4'h8

`define ST_OWN_WRITE 8'h60
`define ST_ARB_OWN_WRITE 8'h68
`define ST_GC 8'h70
`define ST_ARB_GC 8'h78
`define ST_OWN_DATA_ACK 8'h80
`define ST_OWN_DATA_NACK 8'h88
`define ST_GC_DATA_ACK 8'h90
`define ST_GC_DATA_NACK 8'h98
`define ST_NO_INFO 8'hF8

`endif

// >>> src/rx_pkg.sv
/*
 Types of the two-wire slave receiver.
 Assumes nothing of its surroundings.
*/
package rx_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RECV = 3'h1,
      ST_ACKSET = 3'h3,
      ST_ACKBIT = 3'h2,
      ST_HOLD = 3'h6
   } rx_state_t;
   typedef logic [7:0] byte_t;
endpackage

// >>> src/line_if.sv
/*
 Synchronised bus line levels and events, passed from the line monitor
 to its users. Assumes every member is driven on clk by the monitor.
*/
`timescale 1ns/1ns
`default_nettype none
interface line_if;
   logic scl_level;
   logic sda_level;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   modport mon (output scl_level, sda_level, scl_rise, scl_fall, start_seen, stop_seen);
   modport user (input scl_level, sda_level, scl_rise, scl_fall, start_seen, stop_seen);
endinterface
`default_nettype wire

// >>> src/line_monitor.sv
/*
 Two-flop synchronisers for the clock and data lines, edge finder and
 START/STOP detector. Assumes the pins idle high and change slowly
 against clk.
*/
`timescale 1ns/1ns
`default_nettype none
module line_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Bus pins
   input wire logic scl_pin,
   input wire logic sda_pin,
   // Events
   line_if.mon mon
);
   logic [1:0] pins;
   logic [1:0] synced;
   logic [1:0] last;
   assign pins = {sda_pin, scl_pin};

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_sync
         logic stage1_reg;
         logic stage2_reg;
         logic last_reg;
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               stage1_reg <= 1'b1;
               stage2_reg <= 1'b1;
               last_reg <= 1'b1;
            end else begin
               stage1_reg <= pins[i];
               stage2_reg <= stage1_reg;
               last_reg <= stage2_reg;
            end
         end
         assign synced[i] = stage2_reg;
         assign last[i] = last_reg;
      end
   endgenerate

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mon.scl_level <= 1'b1;
         mon.sda_level <= 1'b1;
         mon.scl_rise <= 1'b0;
         mon.scl_fall <= 1'b0;
         mon.start_seen <= 1'b0;
         mon.stop_seen <= 1'b0;
      end else begin
         mon.scl_level <= synced[0];
         mon.sda_level <= synced[1];
         mon.scl_rise <= synced[0] & ~last[0];
         mon.scl_fall <= ~synced[0] & last[0];
         mon.start_seen <= synced[0] & last[0] & ~synced[1] & last[1];
         mon.stop_seen <= synced[0] & last[0] & synced[1] & ~last[1];
      end
   end
endmodule
`default_nettype wire

// >>> src/bit_shifter.sv
/*
 Serial-in byte shifter: samples data on each clock rise while enabled.
 Assumes line events from the line monitor on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "i2c_slave_receiver_regs.svh"
module bit_shifter
   import rx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Line events
   line_if.user line,
   // Control and result
   input wire logic enable,
   output var byte_t byte_val,
   output logic byte_done
);
   logic [3:0] count_reg;
   logic [3:0] count_next;
   wire take_bit = enable & line.scl_rise;
   assign count_next = (count_reg == `BITS_PER_BYTE - 4'h1) ? 4'h0 : count_reg + 4'h1;

   // Bits stop moving while disabled, so a caught byte stays put
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_reg <= 4'h0;
         byte_val <= 8'h00;
         byte_done <= 1'b0;
      end else begin
         byte_done <= take_bit & (count_reg == `BITS_PER_BYTE - 4'h1);
         if (line.start_seen || !enable) begin
            count_reg <= 4'h0;
         end else if (take_bit) begin
            count_reg <= count_next;
            byte_val <= {byte_val[6:0], line.sda_level};
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/i2c_slave_receiver.sv
/*
 Slave-receiver part of a byte-oriented two-wire unit with an APB
 register port. Assumes an open-drain bus with pull-ups outside, a power
 manager that drives sleep_mode on clk, and a master section that pulses
 arb_lost_in when it loses arbitration.
*/
`timescale 1ns/1ns
`default_nettype none
`include "i2c_slave_receiver_regs.svh"
module i2c_slave_receiver
   import rx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Two-wire bus pins, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // System side
   input wire logic sleep_mode,
   input wire logic arb_lost_in,
   output logic wake_request,
   output logic start_issue
);
   function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] offset);
      is_reg = (addr == offset);
   endfunction

   line_if line ();
   byte_t rx_byte;
   logic byte_done;
   rx_state_t state_reg;
   rx_state_t state_next;

   line_monitor u_monitor (
      .clk(clk),
      .reset(reset),
      .scl_pin(scl_in),
      .sda_pin(sda_in),
      .mon(line)
   );

   bit_shifter u_shifter (
      .clk(clk),
      .reset(reset),
      .line(line),
      .enable(state_reg == ST_RECV),
      .byte_val(rx_byte),
      .byte_done(byte_done)
   );

   // Software-visible registers
   byte_t own_addr_reg;
   logic ack_en_reg;
   logic sta_reg;
   logic sto_reg;
   logic en_reg;
   logic flag_reg;
   byte_t status_reg;
   byte_t data_reg;

   // Transfer state
   logic addr_phase_reg;
   logic addr_phase_next;
   logic gc_sel_reg;
   logic gc_sel_next;
   logic end_after_reg;
   logic end_after_next;
   byte_t pend_status_reg;
   byte_t pend_status_next;
   logic drive_ack_reg;
   logic drive_ack_next;
   logic load_data;
   logic set_flag;
   logic arb_lost_reg;
   logic wake_reg;
   logic bus_free_reg;
   logic start_pend_reg;

   // APB decode
   wire apb_setup = psel & ~penable;
   wire apb_write = psel & penable & pready & pwrite;
   wire wr_own = apb_write & is_reg(paddr, `OWN_ADDR_OFFSET);
   wire wr_ctrl = apb_write & is_reg(paddr, `CONTROL_OFFSET);
   wire flag_clear = wr_ctrl & pwdata[`CTRL_INT_BIT];
   wire addr_mapped = is_reg(paddr, `OWN_ADDR_OFFSET) | is_reg(paddr, `CONTROL_OFFSET)
      | is_reg(paddr, `STATUS_OFFSET) | is_reg(paddr, `DATA_OFFSET);
   wire [7:0] ctrl_view = {flag_reg, ack_en_reg, sta_reg, sto_reg, 1'b0, en_reg, 2'b00};
   // Prescaler bits always read as zero here
   wire [7:0] status_view = status_reg & `PRESCALER_MASK;
   wire [7:0] rd_byte = is_reg(paddr, `OWN_ADDR_OFFSET) ? own_addr_reg
      : is_reg(paddr, `CONTROL_OFFSET) ? ctrl_view
      : is_reg(paddr, `STATUS_OFFSET) ? status_view
      : is_reg(paddr, `DATA_OFFSET) ? data_reg : 8'h00;

   // Address recognition
   wire own_match = (rx_byte[7:1] == own_addr_reg[7:1]);
   wire gc_match = (rx_byte == `GENERAL_CALL_ADDR) & own_addr_reg[`GC_ENABLE_BIT];
   wire write_dir = ~rx_byte[0];
   // A read request is left to the transmitter side and not answered here
   wire addr_ok = en_reg & ack_en_reg & write_dir & (own_match | gc_match);
   wire [7:0] addr_status = (own_match & ~gc_match)
      ? (arb_lost_reg ? `ST_ARB_OWN_WRITE : `ST_OWN_WRITE)
      : (arb_lost_reg ? `ST_ARB_GC : `ST_GC);
   wire [7:0] data_status = gc_sel_reg
      ? (ack_en_reg ? `ST_GC_DATA_ACK : `ST_GC_DATA_NACK)
      : (ack_en_reg ? `ST_OWN_DATA_ACK : `ST_OWN_DATA_NACK);
   wire release_hold = (state_reg == ST_HOLD) & ~flag_reg;

   always_comb begin
      state_next = state_reg;
      addr_phase_next = addr_phase_reg;
      gc_sel_next = gc_sel_reg;
      end_after_next = end_after_reg;
      pend_status_next = pend_status_reg;
      drive_ack_next = drive_ack_reg;
      load_data = 1'b0;
      set_flag = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            drive_ack_next = 1'b0;
            if (line.start_seen && en_reg) begin
               state_next = ST_RECV;
               addr_phase_next = 1'b1;
            end
         end
         ST_RECV: begin
            if (byte_done) begin
               state_next = ST_ACKSET;
            end
         end
         ST_ACKSET: begin
            if (line.scl_fall) begin
               if (addr_phase_reg) begin
                  if (addr_ok) begin
                     state_next = ST_ACKBIT;
                     drive_ack_next = 1'b1;
                     gc_sel_next = gc_match & ~own_match;
                     end_after_next = 1'b0;
                     pend_status_next = addr_status;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end else begin
                  // Ack enable is sampled per byte, so a late clear still nacks
                  state_next = ST_ACKBIT;
                  drive_ack_next = ack_en_reg;
                  end_after_next = ~ack_en_reg;
                  pend_status_next = data_status;
                  load_data = 1'b1;
               end
            end
         end
         ST_ACKBIT: begin
            if (line.scl_fall) begin
               state_next = ST_HOLD;
               drive_ack_next = 1'b0;
               set_flag = 1'b1;
            end
         end
         ST_HOLD: begin
            if (!flag_reg) begin
               state_next = end_after_reg ? ST_IDLE : ST_RECV;
               addr_phase_next = 1'b0;
            end
         end
         default: begin
            state_next = ST_IDLE;
            drive_ack_next = 1'b0;
         end
      endcase
      // Stop and disable override the byte sequence, and a START does too outside ST_HOLD
      if (!en_reg || line.stop_seen) begin
         state_next = ST_IDLE;
         drive_ack_next = 1'b0;
      end else if (line.start_seen && state_reg != ST_HOLD) begin
         state_next = ST_RECV;
         addr_phase_next = 1'b1;
         drive_ack_next = 1'b0;
      end
   end

   // Control, flag and software registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         own_addr_reg <= `OWN_ADDR_RESET;
         ack_en_reg <= 1'b0;
         sta_reg <= 1'b0;
         sto_reg <= 1'b0;
         en_reg <= 1'b0;
         flag_reg <= 1'b0;
         status_reg <= `ST_NO_INFO;
         data_reg <= 8'h00;
      end else begin
         if (wr_own) begin
            own_addr_reg <= pwdata[7:0];
         end
         if (wr_ctrl) begin
            ack_en_reg <= pwdata[`CTRL_ACK_BIT];
            sta_reg <= pwdata[`CTRL_STA_BIT];
            sto_reg <= pwdata[`CTRL_STO_BIT];
            en_reg <= pwdata[`CTRL_EN_BIT];
         end
         // A flag event in the clearing cycle survives the clear
         flag_reg <= set_flag | (flag_reg & ~flag_clear);
         if (set_flag) begin
            status_reg <= pend_status_reg;
         end else if (release_hold) begin
            status_reg <= `ST_NO_INFO;
         end
         if (load_data) begin
            data_reg <= rx_byte;
         end
      end
   end

   // Transfer state registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         addr_phase_reg <= 1'b1;
         gc_sel_reg <= 1'b0;
         end_after_reg <= 1'b0;
         pend_status_reg <= `ST_NO_INFO;
         drive_ack_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         addr_phase_reg <= addr_phase_next;
         gc_sel_reg <= gc_sel_next;
         end_after_reg <= end_after_next;
         pend_status_reg <= pend_status_next;
         drive_ack_reg <= drive_ack_next;
      end
   end

   // Arbitration, wake-up and queued START
   wire addr_taken = set_flag & addr_phase_reg;
   wire leave_to_idle = release_hold & end_after_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         arb_lost_reg <= 1'b0;
         wake_reg <= 1'b0;
         bus_free_reg <= 1'b1;
         start_pend_reg <= 1'b0;
         start_issue <= 1'b0;
      end else begin
         arb_lost_reg <= arb_lost_in | (arb_lost_reg & ~addr_taken & ~line.stop_seen);
         wake_reg <= (addr_taken & sleep_mode) | (wake_reg & flag_reg);
         bus_free_reg <= line.stop_seen | (bus_free_reg & ~line.start_seen);
         start_issue <= start_pend_reg & bus_free_reg;
         if (leave_to_idle && sta_reg) begin
            start_pend_reg <= 1'b1;
         end else if (bus_free_reg) begin
            start_pend_reg <= 1'b0;
         end
      end
   end

   // Pins and bus answers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         wake_request <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         // Holding clock low can block the bus for a long wake-up
         scl_oe_n <= ~(state_next == ST_HOLD);
         sda_oe_n <= ~drive_ack_next;
         wake_request <= (addr_taken & sleep_mode) | (wake_reg & flag_reg);
         pready <= apb_setup;
         if (apb_setup) begin
            prdata <= {24'h00_0000, rd_byte};
            pslverr <= ~addr_mapped;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verif/i2c_rx_monitor.sv
/*
 Checker for the slave receiver top ports.
 Assumes it is bound into i2c_slave_receiver.
*/
`timescale 1ns/1ns
`default_nettype none
`include "i2c_slave_receiver_regs.svh"
module i2c_rx_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Bus pins
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // System side
   input wire logic sleep_mode,
   input wire logic wake_request,
   input wire logic start_issue
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire logic clr_wr = psel && penable && pready && pwrite && paddr == `CONTROL_OFFSET && pwdata[7];
   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("ready too long");
   chk_unmapped_err: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04,
      8'h08, 8'h0C}))
      else $error("wrong slave error");
   chk_status_prescaler: assert property (pready && paddr == `STATUS_OFFSET |-> prdata[1:0] == 2'h0)
      else $error("prescaler bits set");
   chk_open_drain: assert property (!scl_out && !sda_out)
      else $error("line driven high");
   chk_ack_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("data line moved with clock high");
   chk_stretch_low: assert property ($fell(scl_oe_n) |-> !scl_in)
      else $error("stretch began with clock high");
   chk_stretch_release: assert property (clr_wr |-> ##[1:3] scl_oe_n)
      else $error("clock not released");
   chk_wake_clear: assert property (clr_wr |-> ##[1:3] !wake_request)
      else $error("wake not cleared");
   chk_wake_in_sleep: assert property ($rose(wake_request) |-> sleep_mode || $past(sleep_mode))
      else $error("wake outside sleep");
   chk_start_pulse: assert property (start_issue |=> !start_issue)
      else $error("start pulse too long");
endmodule
bind i2c_slave_receiver i2c_rx_monitor u_rx_monitor (.clk, .reset, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_in, .scl_out, .scl_oe_n, .sda_out,
   .sda_oe_n, .sleep_mode, .wake_request, .start_issue);
`default_nettype wire

// >>> verif/wire_master_model.sv
/*
 Two-wire master transmitter with open-drain drives.
 Assumes pull-ups on both wires outside.
*/
`timescale 1ns/1ns
`default_nettype none
module wire_master_model (
   // Resolved lines
   input wire logic scl_line,
   input wire logic sda_line,
   // Drives, low pulls the line
   output logic scl_drv,
   output logic sda_drv
);
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   // Waits out a stretch, so a slow slave never loses a bit
   task automatic scl_up();
      scl_drv = 1'b1;
      wait (scl_line === 1'b1);
      #80;
   endtask
   task automatic start();
      sda_drv = 1'b1;
      scl_up();
      sda_drv = 1'b0;
      #80;
      scl_drv = 1'b0;
      #80;
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_drv = b[i];
         #80;
         scl_up();
         scl_drv = 1'b0;
      end
      sda_drv = 1'b1;
      #80;
      scl_up();
      ack = !sda_line;
      scl_drv = 1'b0;
   endtask
   task automatic stop();
      sda_drv = 1'b0;
      #80;
      scl_up();
      sda_drv = 1'b1;
      #80;
   endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
/*
 Self-checking bench: APB tasks and a two-wire master model.
 Assumes package, header and design compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "i2c_slave_receiver_regs.svh"
module testbench import rx_pkg::*;;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_mode = 1'b0, arb_lost_in = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, wake_request, start_issue;
   logic m_scl, m_sda, ack, err;
   int n_errors = 0, checked = 0, n_start = 0;
   wire logic scl_line = m_scl & (scl_oe_n | scl_out);
   wire logic sda_line = m_sda & (sda_oe_n | sda_out);
   always #5 clk = ~clk;
   i2c_slave_receiver u_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .scl_in(scl_line), .scl_out, .scl_oe_n, .sda_in(sda_line), .sda_out,
      .sda_oe_n, .sleep_mode, .arb_lost_in, .wake_request, .start_issue);
   wire_master_model u_master (.scl_line, .sda_line, .scl_drv(m_scl), .sda_drv(m_sda));
   always @(posedge clk) begin
      if (start_issue === 1'b1) n_start++;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      #1;
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 20) begin
         n_errors++;
         $display("CHECK FAILED at %0t: no ready", $time);
      end
      @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Status is masked so prescaler bits never decide a match
   task automatic xfer(input byte_t b, input logic exp_ack, input logic [7:0] exp_st);
      u_master.send(b, ack);
      check({31'h0, ack}, {31'h0, exp_ack}, "ack");
      if (exp_st !== 8'h00) begin
         rd = 32'h0;
         for (int i = 0; i < 20 && rd[7] !== 1'b1; i++) apb(1'b0, `CONTROL_OFFSET, 32'h0);
         apb(1'b0, `STATUS_OFFSET, 32'h0);
         check(rd & {24'h0, `PRESCALER_MASK}, {24'h0, exp_st}, "status");
      end
   endtask
   task automatic arb_pulse();
      @(posedge clk);
      arb_lost_in <= 1'b1;
      @(posedge clk);
      arb_lost_in <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("Errors %0d, checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #600000;
      n_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      apb(1'b0, `STATUS_OFFSET, 32'h0);
      check(rd, 32'hF8, "status reset");
      apb(1'b0, 8'h10, 32'h0);
      check({31'h0, err}, 32'h1, "unmapped");
      apb(1'b1, `OWN_ADDR_OFFSET, 32'hB5);
      apb(1'b0, `OWN_ADDR_OFFSET, 32'h0);
      check(rd, 32'hB5, "own address");
      apb(1'b1, `CONTROL_OFFSET, 32'h44);
      u_master.start();
      xfer(8'h66, 1'b0, 8'h00);
      u_master.stop();
      u_master.start();
      xfer(8'hB4, 1'b1, 8'h60);
      apb(1'b1, `CONTROL_OFFSET, 32'hC4);
      xfer(8'hA5, 1'b1, 8'h80);
      apb(1'b0, `DATA_OFFSET, 32'h0);
      check(rd, 32'hA5, "data");
      apb(1'b1, `CONTROL_OFFSET, 32'h84);
      xfer(8'h3C, 1'b0, 8'h88);
      apb(1'b0, `DATA_OFFSET, 32'h0);
      check(rd, 32'h3C, "data");
      apb(1'b1, `CONTROL_OFFSET, 32'hE4);
      u_master.stop();
      apb(1'b1, `CONTROL_OFFSET, 32'h44);
      check({31'h0, n_start > 0}, 32'h1, "start issue");
      u_master.start();
      xfer(8'hB5, 1'b0, 8'h00);
      u_master.stop();
      u_master.start();
      xfer(8'h00, 1'b1, 8'h70);
      apb(1'b1, `CONTROL_OFFSET, 32'hC4);
      xfer(8'h11, 1'b1, 8'h90);
      apb(1'b1, `CONTROL_OFFSET, 32'h84);
      xfer(8'h22, 1'b0, 8'h98);
      apb(1'b1, `CONTROL_OFFSET, 32'hC4);
      u_master.stop();
      arb_pulse();
      u_master.start();
      xfer(8'hB4, 1'b1, 8'h68);
      apb(1'b1, `CONTROL_OFFSET, 32'hC4);
      xfer(8'h01, 1'b1, 8'h80);
      apb(1'b1, `CONTROL_OFFSET, 32'hC4);
      u_master.stop();
      arb_pulse();
      u_master.start();
      xfer(8'h00, 1'b1, 8'h78);
      apb(1'b1, `CONTROL_OFFSET, 32'hC4);
      u_master.stop();
      apb(1'b1, `CONTROL_OFFSET, 32'h04);
      u_master.start();
      xfer(8'hB4, 1'b0, 8'h00);
      u_master.stop();
      apb(1'b1, `OWN_ADDR_OFFSET, 32'hB4);
      apb(1'b1, `CONTROL_OFFSET, 32'h44);
      u_master.start();
      xfer(8'h00, 1'b0, 8'h00);
      u_master.stop();
      @(posedge clk);
      sleep_mode <= 1'b1;
      u_master.start();
      xfer(8'hB4, 1'b1, 8'h60);
      check({31'h0, wake_request}, 32'h1, "wake");
      check({31'h0, scl_line}, 32'h0, "stretch");
      @(posedge clk);
      sleep_mode <= 1'b0;
      apb(1'b1, `CONTROL_OFFSET, 32'hC4);
      repeat (3) @(posedge clk);
      #1;
      check({31'h0, wake_request}, 32'h0, "wake cleared");
      xfer(8'h5E, 1'b1, 8'h80);
      apb(1'b1, `CONTROL_OFFSET, 32'hC4);
      u_master.stop();
      wrap_up();
   end
endmodule
`default_nettype wire
